// ### src/mps_switch.sv
// Purpose: MII port switch between internal PHY and external MII port
// Assumes: PHY clocks are sampled by clk and rebuilt towards the MAC
// Notes: all outputs are registered; PHY pins pass two flip-flops
//
// Functional notes
// [R01] two-bit clock source field gates both PHY clock pairs, switches glitch-free
// [R02] port select multiplexes all MII signals except management bus and clocks
// [R03] management select routes SMI to internal or external PHY independently
// [R04] host should not change management select during an SMI transaction
// [R05] host gates MII clocks before changing the data multiplexor
// [R06] host halts transmitter then receiver, waiting for each, before switching
// [R07] writing 10b stops both PHY clock pairs to the MAC
// [R08] host waits five slowest running clock periods after gating
// [R09] port select routes RXD, RX_DV, RX_ER, TXD, TX_EN, CRS, COL
// [R10] host then selects the clock source matching the port select
// [R11] host waits five new clock periods, then enables transmitter, receiver
// [R12] stopped clocks of the deselected PHY are left out of the wait
// [R13] the full sequence is run for every port change, either direction
// [R14] running PHY clocks stay clean; stopped ones stay off until done
// [R15] host puts both PHYs into a stable state over SMI first
// [R16] 00b internal, 01b external; every source change passes the gated state
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module mps_switch
  import mps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [mps_pkg::MPS_ADDR_W-1:0] reg_addr,
  input wire logic [mps_pkg::MPS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mps_pkg::MPS_DATA_W-1:0] reg_rdata,
  // MAC side
  input wire logic [3:0] mac_txd,
  input wire logic mac_tx_en,
  output logic [3:0] mac_rxd,
  output logic mac_rx_dv,
  output logic mac_rx_er,
  output logic mac_crs,
  output logic mac_col,
  output logic mac_tx_clk,
  output logic mac_rx_clk,
  // MAC management side
  input wire logic mac_mdc,
  input wire logic mac_mdio_out,
  input wire logic mac_mdio_oe,
  output logic mac_mdio_in,
  // internal PHY
  input wire logic int_tx_clk,
  input wire logic int_rx_clk,
  input wire logic [3:0] int_rxd,
  input wire logic int_rx_dv,
  input wire logic int_rx_er,
  input wire logic int_crs,
  input wire logic int_col,
  output logic [3:0] int_txd,
  output logic int_tx_en,
  output logic int_mdc,
  input wire logic int_mdio_in,
  output logic int_mdio_out,
  output logic int_mdio_oe,
  // external MII port
  input wire logic ext_tx_clk,
  input wire logic ext_rx_clk,
  input wire logic [3:0] ext_rxd,
  input wire logic ext_rx_dv,
  input wire logic ext_rx_er,
  input wire logic ext_crs,
  input wire logic ext_col,
  output logic [3:0] ext_txd,
  output logic ext_tx_en,
  output logic ext_mdc,
  input wire logic ext_mdio_in,
  output logic ext_mdio_out,
  output logic ext_mdio_oe
);
  import mps_pkg::*;

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic int_tx_s, int_rx_s, ext_tx_s, ext_rx_s;
  logic [3:0] int_rxd_s, ext_rxd_s;
  logic int_dv_s, int_er_s, int_crs_s, int_col_s, int_mdio_s;
  logic ext_dv_s, ext_er_s, ext_crs_s, ext_col_s, ext_mdio_s;

  mps_sync #(.W(22)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({int_tx_clk, int_rx_clk, int_rxd, int_rx_dv, int_rx_er, int_crs, int_col,
        int_mdio_in, ext_tx_clk, ext_rx_clk, ext_rxd, ext_rx_dv, ext_rx_er,
        ext_crs, ext_col, ext_mdio_in}),
    .q({int_tx_s, int_rx_s, int_rxd_s, int_dv_s, int_er_s, int_crs_s, int_col_s,
        int_mdio_s, ext_tx_s, ext_rx_s, ext_rxd_s, ext_dv_s, ext_er_s,
        ext_crs_s, ext_col_s, ext_mdio_s})
  );

  // --------------------------------------------------------------------
  // configuration register
  // --------------------------------------------------------------------
  logic [1:0] clk_src;
  logic port_sel;
  logic mgmt_sel;
  mps_clk_state_e clk_state, next_clk_state;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_src <= MPS_CLK_SRC_RESET;
      port_sel <= MPS_PORT_SEL_RESET;
      mgmt_sel <= MPS_MGMT_SEL_RESET;
    end else if (reg_wr && reg_addr == MPS_CFG_OFFSET) begin
      clk_src <= reg_wdata[MPS_CLK_SRC_LSB +: 2];
      port_sel <= reg_wdata[MPS_PORT_SEL_BIT];
      mgmt_sel <= reg_wdata[MPS_MGMT_SEL_BIT];
    end
  end

  function automatic logic [1:0] state_code(input mps_clk_state_e s);
    unique case (s)
      MPS_CLK_INT: state_code = MPS_SRC_INT;
      MPS_CLK_EXT: state_code = MPS_SRC_EXT;
      default: state_code = MPS_SRC_GATE;
    endcase
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == MPS_CFG_OFFSET) begin
      reg_rdata <= {4'h0, mgmt_sel, port_sel, clk_src};
    end else if (reg_rd && reg_addr == MPS_STATUS_OFFSET) begin
      reg_rdata <= {2'h0, mac_rx_clk, mac_tx_clk, 2'h0, state_code(clk_state)};
    end else begin
      reg_rdata <= '0;
    end
  end

  // --------------------------------------------------------------------
  // glitch-free clock selector
  // --------------------------------------------------------------------
  // a source is only left or entered while both of its clocks sit low,
  // so the rebuilt MAC clock never carries a shortened high phase
  logic int_low, ext_low;
  assign int_low = !int_tx_s && !int_rx_s;
  assign ext_low = !ext_tx_s && !ext_rx_s;

  // synchroniser outputs show reset zeros at first; entering a source on
  // those would let a cut high phase reach the MAC
  logic [1:0] sync_age;
  logic sync_ready;
  assign sync_ready = sync_age == 2'(MPS_SYNC_STAGES);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_age <= 2'h0;
    end else if (!sync_ready) begin
      sync_age <= sync_age + 2'h1; // R16
    end
  end

  always_comb begin
    next_clk_state = clk_state;
    unique case (clk_state)
      MPS_CLK_GATED: begin
        if (sync_ready && clk_src == MPS_SRC_INT && int_low) begin
          next_clk_state = MPS_CLK_INT; // R16
        end else if (sync_ready && clk_src == MPS_SRC_EXT && ext_low) begin
          next_clk_state = MPS_CLK_EXT; // R16
        end
      end
      MPS_CLK_INT: begin
        if (clk_src != MPS_SRC_INT && int_low) begin
          next_clk_state = MPS_CLK_GATED; // R01 R07
        end
      end
      MPS_CLK_EXT: begin
        if (clk_src != MPS_SRC_EXT && ext_low) begin
          next_clk_state = MPS_CLK_GATED; // R01 R07
        end
      end
      default: next_clk_state = MPS_CLK_GATED;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_state <= MPS_CLK_GATED;
    end else begin
      clk_state <= next_clk_state;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mac_tx_clk <= 1'b0;
      mac_rx_clk <= 1'b0;
    end else begin
      mac_tx_clk <= (clk_state == MPS_CLK_INT && int_tx_s) ||
                    (clk_state == MPS_CLK_EXT && ext_tx_s); // R01
      mac_rx_clk <= (clk_state == MPS_CLK_INT && int_rx_s) ||
                    (clk_state == MPS_CLK_EXT && ext_rx_s); // R01
    end
  end

  // --------------------------------------------------------------------
  // MII data multiplexor
  // --------------------------------------------------------------------
  // the deselected port sees an idle transmitter, not a copy of the MAC
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_txd <= '0;
      int_tx_en <= 1'b0;
      ext_txd <= '0;
      ext_tx_en <= 1'b0;
    end else begin
      int_txd <= port_sel ? 4'h0 : mac_txd; // R02 R09
      int_tx_en <= !port_sel && mac_tx_en; // R02 R09
      ext_txd <= port_sel ? mac_txd : 4'h0; // R02 R09
      ext_tx_en <= port_sel && mac_tx_en; // R02 R09
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mac_rxd <= '0;
      mac_rx_dv <= 1'b0;
      mac_rx_er <= 1'b0;
      mac_crs <= 1'b0;
      mac_col <= 1'b0;
    end else begin
      mac_rxd <= port_sel ? ext_rxd_s : int_rxd_s; // R02 R09
      mac_rx_dv <= port_sel ? ext_dv_s : int_dv_s; // R09
      mac_rx_er <= port_sel ? ext_er_s : int_er_s; // R09
      mac_crs <= port_sel ? ext_crs_s : int_crs_s; // R09
      mac_col <= port_sel ? ext_col_s : int_col_s; // R09
    end
  end

  // --------------------------------------------------------------------
  // management port routing
  // --------------------------------------------------------------------
  // switching mid-transaction cuts the frame; software must avoid it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_mdc <= 1'b0;
      int_mdio_out <= 1'b0;
      int_mdio_oe <= 1'b0;
      ext_mdc <= 1'b0;
      ext_mdio_out <= 1'b0;
      ext_mdio_oe <= 1'b0;
      mac_mdio_in <= 1'b0;
    end else begin
      int_mdc <= !mgmt_sel && mac_mdc; // R03
      int_mdio_out <= !mgmt_sel && mac_mdio_out; // R03
      int_mdio_oe <= !mgmt_sel && mac_mdio_oe; // R03
      ext_mdc <= mgmt_sel && mac_mdc; // R03
      ext_mdio_out <= mgmt_sel && mac_mdio_out; // R03
      ext_mdio_oe <= mgmt_sel && mac_mdio_oe; // R03
      mac_mdio_in <= mgmt_sel ? ext_mdio_s : int_mdio_s; // R03
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  sequence s_leave_gate;
    clk_state == MPS_CLK_GATED ##1 clk_state != MPS_CLK_GATED;
  endsequence

  sequence s_enter_gate;
    clk_state != MPS_CLK_GATED ##1 clk_state == MPS_CLK_GATED;
  endsequence

  chk_gated_quiet: assert property (@(posedge clk) disable iff (!rstn) // R07
    clk_state == MPS_CLK_GATED |=> !mac_tx_clk && !mac_rx_clk)
    else $error("MAC clock active while gated");

  chk_no_direct_swap: assert property (@(posedge clk) disable iff (!rstn) // R16
    clk_state != MPS_CLK_GATED |=> clk_state == $past(clk_state) ||
                                   clk_state == MPS_CLK_GATED)
    else $error("clock source changed without passing the gated state");

  chk_enter_low: assert property (@(posedge clk) disable iff (!rstn) // R01
    s_leave_gate |-> ((clk_state == MPS_CLK_INT) ? $past(int_low) : $past(ext_low)))
    else $error("clock source entered while its clock was high");

  chk_gate_clean: assert property (@(posedge clk) disable iff (!rstn) // R01
    s_enter_gate |-> !mac_tx_clk && !mac_rx_clk ##1 !mac_tx_clk && !mac_rx_clk)
    else $error("clock gated during a high phase");

  chk_gate_request: assert property (@(posedge clk) disable iff (!rstn) // R07
    clk_src == MPS_SRC_GATE ##1 clk_src == MPS_SRC_GATE |-> 
      clk_state == MPS_CLK_GATED || $past(clk_state) == clk_state)
    else $error("gate request moved to a live source");

  chk_rx_route: assert property (@(posedge clk) disable iff (!rstn) // R09
    port_sel |=> mac_rxd == $past(ext_rxd_s) && mac_col == $past(ext_col_s))
    else $error("receive path not routed to the external port");

  chk_tx_route: assert property (@(posedge clk) disable iff (!rstn) // R02
    !port_sel |=> int_tx_en == $past(mac_tx_en) && !ext_tx_en && ext_txd == 4'h0)
    else $error("transmit path not routed to the internal PHY");

  chk_mgmt_route: assert property (@(posedge clk) disable iff (!rstn) // R03
    mgmt_sel |=> ext_mdc == $past(mac_mdc) && !int_mdio_oe &&
                 mac_mdio_in == $past(ext_mdio_s))
    else $error("management port not routed to the external port");
endmodule // mps_switch

// ### src/mps_pkg.sv
// Purpose: shared constants for the MII port switch
// Assumes: plain register port, 4-bit word address, 8-bit data
// Notes: clock source codes follow the switching field encoding
package mps_pkg;
  // --------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------
  localparam int MPS_ADDR_W = 4;
  localparam int MPS_DATA_W = 8;
  localparam logic [3:0] MPS_CFG_OFFSET = 4'h0;
  localparam logic [3:0] MPS_STATUS_OFFSET = 4'h1;
  // --------------------------------------------------------------------
  // configuration fields
  // --------------------------------------------------------------------
  localparam int MPS_CLK_SRC_LSB = 0;
  localparam int MPS_PORT_SEL_BIT = 2;
  localparam int MPS_MGMT_SEL_BIT = 3;
  localparam logic [1:0] MPS_SRC_INT = 2'h0;
  localparam logic [1:0] MPS_SRC_EXT = 2'h1;
  localparam logic [1:0] MPS_SRC_GATE = 2'h2;
  localparam logic [1:0] MPS_CLK_SRC_RESET = 2'h0;
  localparam logic MPS_PORT_SEL_RESET = 1'b0;
  localparam logic MPS_MGMT_SEL_RESET = 1'b0;
  // --------------------------------------------------------------------
  // status fields
  // --------------------------------------------------------------------
  localparam int MPS_ST_ACTIVE_LSB = 0;
  localparam int MPS_ST_LEVEL_LSB = 2;
  localparam int MPS_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    MPS_CLK_GATED,
    MPS_CLK_INT,
    MPS_CLK_EXT
  } mps_clk_state_e;
endpackage

// ### src/mps_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are levels from outside the clk domain
// Notes: the first stage is read only by the second
`timescale 1ns/1ps
module mps_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // mps_sync

// ### sim/mps_phy_model.sv
// Purpose: behavioural MII PHY for the port switch bench
// Assumes: free-running 200 ns MII clocks, phase set by OFS
// Notes: receive side shows a fixed pattern so the mux choice is visible
`timescale 1ns/1ps
module mps_phy_model #(
  parameter real OFS = 0.0,
  parameter logic [3:0] PAT = 4'h5,
  parameter logic REPLY = 1'b0
) (
  // MII receive side
  output logic tx_clk,
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  // management
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdio_in
);
  // ----------
  // clocks
  // ----------
  initial begin
    tx_clk = 1'b0;
    #(OFS);
    forever #100 tx_clk = ~tx_clk;
  end
  // rx lags tx so both share a low phase, as a real PHY would
  assign #20 rx_clk = tx_clk;
  // ----------
  // data, held stable around the switch
  // ----------
  assign rxd = PAT;
  // control bits carry the inverse so every bit shows both levels
  assign {rx_dv, rx_er, crs, col} = ~PAT;
  assign mdio_in = mdio_oe ? mdio_out : REPLY;
endmodule // mps_phy_model

// ### sim/tb_mps_switch.sv
// Purpose: self-checking bench for the MII port switch
// Assumes: both PHY models run 200 ns clocks with unrelated phase
// Notes: host switching sequence lives in switch_to
`timescale 1ns/1ps
module tb_mps_switch;
  import mps_pkg::*;
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] txd;
    logic [7:0] rx;
    logic [2:0] mg;
  } mps_row_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] mac_txd = 4'h0;
  logic mac_tx_en = 1'b0;
  logic mac_mdc = 1'b1;
  logic mac_mdio_out = 1'b0;
  logic mac_mdio_oe = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] cur = 8'h00;
  logic [3:0] mac_rxd, int_rxd, ext_rxd, int_txd, ext_txd;
  logic mac_rx_dv, mac_rx_er, mac_crs, mac_col, mac_tx_clk, mac_rx_clk, mac_mdio_in;
  logic int_tx_clk, int_rx_clk, int_rx_dv, int_rx_er, int_crs, int_col, int_tx_en;
  logic ext_tx_clk, ext_rx_clk, ext_rx_dv, ext_rx_er, ext_crs, ext_col, ext_tx_en;
  logic int_mdc, int_mdio_in, int_mdio_out, int_mdio_oe;
  logic ext_mdc, ext_mdio_in, ext_mdio_out, ext_mdio_oe;
  int n_mismatch = 0;
  int checked = 0;
  mps_row_s rows [4];

  always #12.5 clk = ~clk;

  mps_switch DUT (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .mac_txd, .mac_tx_en, .mac_rxd, .mac_rx_dv, .mac_rx_er, .mac_crs, .mac_col,
    .mac_tx_clk, .mac_rx_clk, .mac_mdc, .mac_mdio_out, .mac_mdio_oe, .mac_mdio_in,
    .int_tx_clk, .int_rx_clk, .int_rxd, .int_rx_dv, .int_rx_er, .int_crs, .int_col,
    .int_txd, .int_tx_en, .int_mdc, .int_mdio_in, .int_mdio_out, .int_mdio_oe,
    .ext_tx_clk, .ext_rx_clk, .ext_rxd, .ext_rx_dv, .ext_rx_er, .ext_crs, .ext_col,
    .ext_txd, .ext_tx_en, .ext_mdc, .ext_mdio_in, .ext_mdio_out, .ext_mdio_oe);
  mps_phy_model #(.OFS(0.0), .PAT(4'h5), .REPLY(1'b0)) int_phy (.tx_clk(int_tx_clk),
    .rx_clk(int_rx_clk), .rxd(int_rxd), .rx_dv(int_rx_dv), .rx_er(int_rx_er),
    .crs(int_crs), .col(int_col), .mdio_out(int_mdio_out), .mdio_oe(int_mdio_oe),
    .mdio_in(int_mdio_in));
  mps_phy_model #(.OFS(37.0), .PAT(4'hA), .REPLY(1'b1)) ext_phy (.tx_clk(ext_tx_clk),
    .rx_clk(ext_rx_clk), .rxd(ext_rxd), .rx_dv(ext_rx_dv), .rx_er(ext_rx_er),
    .crs(ext_crs), .col(ext_col), .mdio_out(ext_mdio_out), .mdio_oe(ext_mdio_oe),
    .mdio_in(ext_mdio_in));

  // ----------
  // tasks
  // ----------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // counts rising edges of both MAC clocks after a settling gap
  task automatic edges(input int n, output logic [7:0] tc, output logic [7:0] rc);
    logic pt;
    logic pr;
    repeat (8) @(posedge clk);
    #1;
    tc = 8'h00;
    rc = 8'h00;
    pt = mac_tx_clk;
    pr = mac_rx_clk;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (mac_tx_clk && !pt) tc++;
      if (mac_rx_clk && !pr) rc++;
      pt = mac_tx_clk;
      pr = mac_rx_clk;
    end
  endtask

  task automatic switch_to(input logic [7:0] cfg);
    logic [7:0] st;
    logic [7:0] tc;
    logic [7:0] rc;
    @(posedge clk);
    mac_tx_en <= 1'b0;
    wr(MPS_CFG_OFFSET, {cur[7:2], MPS_SRC_GATE});
    edges(40, tc, rc);
    cmp(tc | rc, 8'h00, "gated clocks");
    rd(MPS_STATUS_OFFSET, st);
    cmp(st, {6'h0, MPS_SRC_GATE}, "gated status");
    wr(MPS_CFG_OFFSET, {cfg[7:2], MPS_SRC_GATE});
    wr(MPS_CFG_OFFSET, {cfg[7:2], 1'b0, cfg[2]});
    edges(80, tc, rc);
    cmp({6'h0, tc >= 9 && tc <= 11, rc >= 9 && rc <= 11}, 8'h03, "clock edges");
    @(posedge clk);
    mac_tx_en <= 1'b1;
    cur = {cfg[7:2], 1'b0, cfg[2]};
  endtask

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------
  // sequence
  // ----------
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] tc;
    logic [7:0] rc;
    rows[0] = '{8'h00, 4'h3, 8'h5A, 3'b100};
    rows[1] = '{8'h04, 4'hC, 8'hA5, 3'b100};
    rows[2] = '{8'h0C, 4'h6, 8'hA5, 3'b011};
    rows[3] = '{8'h08, 4'h9, 8'h5A, 3'b011};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(MPS_CFG_OFFSET, d);
    cmp(d, 8'h00, "cfg reset");
    repeat (8) @(posedge clk);
    rd(MPS_STATUS_OFFSET, d);
    cmp(d & 8'h03, {6'h0, MPS_SRC_INT}, "reset source");
    foreach (rows[i]) begin
      @(posedge clk);
      mac_txd <= rows[i].txd;
      switch_to(rows[i].cfg);
      repeat (4) @(posedge clk);
      #1;
      cmp({mac_rxd, mac_rx_dv, mac_rx_er, mac_crs, mac_col}, rows[i].rx, "rx path");
      cmp({3'h0, int_txd, int_tx_en}, rows[i].cfg[2] ? 8'h00 : {3'h0, rows[i].txd, 1'b1},
        "int tx");
      cmp({3'h0, ext_txd, ext_tx_en}, rows[i].cfg[2] ? {3'h0, rows[i].txd, 1'b1} : 8'h00,
        "ext tx");
      cmp({5'h0, int_mdc, ext_mdc, mac_mdio_in}, {5'h0, rows[i].mg}, "mgmt path");
      rd(MPS_STATUS_OFFSET, d);
      cmp(d & 8'h03, {7'h0, rows[i].cfg[2]}, "active source");
    end
    // stray writes must leave the configuration alone
    wr(4'h7, 8'hFF);
    wr(MPS_STATUS_OFFSET, 8'hFF);
    rd(MPS_CFG_OFFSET, d);
    cmp(d, cur, "cfg after stray writes");
    rd(4'h7, d);
    cmp(d, 8'h00, "unmapped read");
    // management drive towards the external port, with the PHY echoing mdio
    mac_mdio_oe <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    cmp({1'b0, int_mdc, int_mdio_out, int_mdio_oe, ext_mdc, ext_mdio_out, ext_mdio_oe,
      mac_mdio_in}, 8'h0A, "mdio drive low");
    @(posedge clk);
    mac_mdio_out <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    cmp({1'b0, int_mdc, int_mdio_out, int_mdio_oe, ext_mdc, ext_mdio_out, ext_mdio_oe,
      mac_mdio_in}, 8'h0F, "mdio drive high");
    @(posedge clk);
    mac_mdio_oe <= 1'b0;
    mac_mdio_out <= 1'b0;
    wr(MPS_CFG_OFFSET, 8'h03);
    edges(40, tc, rc);
    cmp(tc | rc, 8'h00, "code 11 clocks");
    rd(MPS_STATUS_OFFSET, d);
    cmp(d, {6'h0, MPS_SRC_GATE}, "code 11 status");
    wr(MPS_CFG_OFFSET, 8'h00);
    edges(40, tc, rc);
    // direct source change without host gating still lands cleanly
    wr(MPS_CFG_OFFSET, 8'h05);
    edges(40, tc, rc);
    rd(MPS_STATUS_OFFSET, d);
    cmp(d & 8'h03, {6'h0, MPS_SRC_EXT}, "direct switch");
    @(posedge clk);
    rstn <= 1'b0;
    #1;
    cmp({mac_tx_clk, mac_rx_clk, mac_rx_dv, ext_tx_en, int_mdc, ext_mdc, 2'b00}, 8'h00,
      "outputs in reset");
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(MPS_CFG_OFFSET, d);
    cmp(d, 8'h00, "cfg after reset");
    print_verdict();
  end
endmodule // tb_mps_switch
